// File: rtl/uap_params.svh
// register map, field positions and reset values of the serial port
`ifndef UAP_PARAMS_SVH
`define UAP_PARAMS_SVH

`define UAP_ADDR_CFG      32'h40000200
`define UAP_ADDR_EN       32'h40000201
`define UAP_ADDR_DIV_LO   32'h40000202
`define UAP_ADDR_DIV_HI   32'h40000203
`define UAP_ADDR_LINE     32'h40000204
`define UAP_ADDR_IRQ      32'h40000208
`define UAP_ADDR_RXBUF    32'h4000020C
`define UAP_ADDR_TXBUF    32'h4000020E

`define UAP_EN_BIT        0
`define UAP_IRQ_RX_BIT    0
`define UAP_IRQ_TX_BIT    1

`define UAP_CFG_RST       8'h00
`define UAP_EN_RST        8'h00
`define UAP_DIV_RST       8'h00
`define UAP_LINE_RST      8'h00
`define UAP_BYTE_ZERO     8'h00

`define UAP_DATA_BITS     8
`define UAP_TXFIFO_DEPTH  16

`endif

// File: rtl/uap_pkg.sv
// types shared by the serial port files
package uap_pkg;

  typedef struct packed {
    logic [4:0] unused;
    logic       two_stop;
    logic       even;
    logic       par_en;
  } uap_cfg_t;

  typedef struct packed {
    logic [2:0] unused;
    logic       tx_done;
    logic       rx_ready;
    logic       fe;
    logic       pe;
    logic       oe;
  } uap_line_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uap_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uap_rx_state_t;

endpackage

// File: rtl/uap_bitclk.sv
// bit-period counter: one-cycle tick every divisor+1 clocks while running
`timescale 1ns/1ps
module uap_bitclk #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk,  // system clock
  input  wire logic             rst,      // async reset, active high
  input  wire logic             run,      // count while high
  input  wire logic [WIDTH-1:0] divisor,  // period minus one
  input  wire logic [WIDTH-1:0] preset,   // count held here while idle
  output logic                  tick      // end of a bit period
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  if (WIDTH < 2) begin : g_bad_width
    $error("uap_bitclk: WIDTH must be at least 2");
  end

  always_comb begin
    tick       = run && (count_reg == divisor);
    count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    if (!run) begin
      count_next = preset;
    end else if (tick) begin
      count_next = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule

// File: rtl/uap_fifo.sv
// first-word-fall-through fifo with valid/ready on both sides
`timescale 1ns/1ps
module uap_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,    // system clock
  input  wire logic             rst,        // async reset, active high
  input  wire logic             in_valid,   // write request
  output logic                  in_ready,   // room for a word
  input  wire logic [WIDTH-1:0] in_data,    // word written
  output logic                  out_valid,  // word available
  input  wire logic             out_ready,  // consumer takes the word
  output logic      [WIDTH-1:0] out_data    // oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    wptr_next;
  logic [AW-1:0]    rptr_reg;
  logic [AW-1:0]    rptr_next;
  logic [AW:0]      fill_reg;
  logic [AW:0]      fill_next;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("uap_fifo: DEPTH must be a power of two, at least 2");
  end

  always_comb begin
    in_ready  = (fill_reg != DEPTH[AW:0]);
    out_valid = (fill_reg != '0);
    out_data  = mem_reg[rptr_reg];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wptr_next = push ? wptr_reg + {{(AW-1){1'b0}}, 1'b1} : wptr_reg;
    rptr_next = pop ? rptr_reg + {{(AW-1){1'b0}}, 1'b1} : rptr_reg;
    fill_next = fill_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      fill_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      fill_reg <= fill_next;
    end
  end
endmodule

// File: rtl/uap_serial_port.sv
// asynchronous serial port with its memory-mapped registers
`timescale 1ns/1ps
`include "uap_params.svh"

// How it works
// - cfg bit0 parity on, bit1 even else odd
// - cfg bit2 selects two stop bits
// - enable bit0 off stops transmit and receive
// - unread buffer overwritten sets overrun flag
// - overrun clears on status read after buffer read
// - parity mismatch sets parity error flag
// - parity error clears status-after-buffer read only
// - missing stop bit sets framing error flag
// - framing error clears status-after-buffer read
// - status bit3 shows unread received character
// - reading receive buffer clears ready flag
// - status bit4 set after character fully sent with transmit fifo empty
// - writing transmit buffer clears complete flag
// - receive buffer holds latest character, read-only
// - transmit buffer write queues byte in transmit fifo, dropped if full
// - interrupt flags rx bit0, tx bit1, w1c
module uap_serial_port
  import uap_pkg::*;
#(
  parameter int FIFO_DEPTH = `UAP_TXFIFO_DEPTH
) (
  input  wire logic        sys_clk,       // system clock, 100 MHz
  input  wire logic        rst,           // async reset, active high
  input  wire logic [31:0] bus_addr,      // processor byte address
  input  wire logic        bus_wr,        // write strobe
  input  wire logic        bus_rd,        // read strobe
  input  wire logic [7:0]  bus_wdata,     // write data
  output logic      [7:0]  bus_rdata,     // read data, valid after a read
  input  wire logic        rx_line_in,    // serial receive pin
  output logic             tx_line_out,   // serial transmit pin, idle high
  output logic             tx_space_ok    // transmit fifo had room
);
  localparam int DW = `UAP_DATA_BITS;

  uap_cfg_t      cfg_reg;
  uap_cfg_t      cfg_next;
  logic [7:0]    en_reg;
  logic [7:0]    en_next;
  logic [7:0]    div_lo_reg;
  logic [7:0]    div_lo_next;
  logic [7:0]    div_hi_reg;
  logic [7:0]    div_hi_next;
  uap_line_t     ls_reg;
  uap_line_t     ls_next;
  logic          rx_pending_irq_flag_reg;
  logic          rx_pending_irq_flag_next;
  logic          tx_done_irq_flag_reg;
  logic          tx_done_irq_flag_next;
  logic [DW-1:0] rxbuf_reg;
  logic [DW-1:0] rxbuf_next;
  logic          rxbuf_seen_reg;
  logic          rxbuf_seen_next;
  logic [7:0]    rdata_reg;
  logic [7:0]    rdata_next;
  logic          space_reg;
  logic          rx_meta_reg;
  logic          rx_sync_reg;

  uap_tx_state_t tx_st_reg;
  uap_tx_state_t tx_st_next;
  logic [DW-1:0] tx_sh_reg;
  logic [DW-1:0] tx_sh_next;
  logic [2:0]    tx_cnt_reg;
  logic [2:0]    tx_cnt_next;
  logic          tx_par_reg;
  logic          tx_par_next;
  logic          tx_two_reg;
  logic          tx_two_next;
  logic          tx_line_reg;
  logic          tx_line_next;

  uap_rx_state_t rx_st_reg;
  uap_rx_state_t rx_st_next;
  logic [DW-1:0] rx_sh_reg;
  logic [DW-1:0] rx_sh_next;
  logic [2:0]    rx_cnt_reg;
  logic [2:0]    rx_cnt_next;
  logic          rx_two_reg;
  logic          rx_two_next;
  logic          rx_perr_reg;
  logic          rx_perr_next;
  logic          rx_fe_reg;
  logic          rx_fe_next;

  logic          port_on;
  logic [15:0]   divisor;
  logic          tx_tick;
  logic          rx_tick;
  logic          fifo_in_rdy;
  logic          fifo_vld;
  logic [DW-1:0] fifo_data;
  logic          tx_push;
  logic          tx_pop;
  logic          tx_done_evt;
  logic          rx_deliver;
  logic          rx_fe_now;
  logic          rxbuf_rd;
  logic          ls_rd;

  function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
    hit = (addr == target);
  endfunction

  assign port_on  = en_reg[`UAP_EN_BIT];
  assign divisor  = {div_hi_reg, div_lo_reg};
  assign rxbuf_rd = bus_rd && hit(bus_addr, `UAP_ADDR_RXBUF);
  assign ls_rd    = bus_rd && hit(bus_addr, `UAP_ADDR_LINE);
  assign tx_push  = bus_wr && hit(bus_addr, `UAP_ADDR_TXBUF) && fifo_in_rdy;

  assign bus_rdata   = rdata_reg;
  assign tx_line_out = tx_line_reg;
  assign tx_space_ok = space_reg;

  uap_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_txfifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (tx_push),
    .in_ready  (fifo_in_rdy),
    .in_data   (bus_wdata),
    .out_valid (fifo_vld),
    .out_ready (tx_pop),
    .out_data  (fifo_data)
  );

  uap_bitclk #(.WIDTH(16)) u_txclk (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (tx_st_reg != TX_IDLE),
    .divisor (divisor),
    .preset  (16'h0000),
    .tick    (tx_tick)
  );

  // receive counter starts half a period in, so it samples mid-bit
  uap_bitclk #(.WIDTH(16)) u_rxclk (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (rx_st_reg != RX_IDLE),
    .divisor (divisor),
    .preset  ({1'b0, divisor[15:1]}),
    .tick    (rx_tick)
  );

  // transmitter
  always_comb begin
    tx_st_next   = tx_st_reg;
    tx_sh_next   = tx_sh_reg;
    tx_cnt_next  = tx_cnt_reg;
    tx_par_next  = tx_par_reg;
    tx_two_next  = tx_two_reg;
    tx_line_next = tx_line_reg;
    tx_pop       = 1'b0;
    tx_done_evt  = 1'b0;
    if (!port_on) begin
      tx_st_next   = TX_IDLE;
      tx_line_next = 1'b1;
    end else begin
      unique case (tx_st_reg)
        TX_IDLE: if (fifo_vld) begin
          tx_pop       = 1'b1;
          tx_sh_next   = fifo_data;
          tx_par_next  = cfg_reg.even ? ^fifo_data : ~^fifo_data;
          tx_cnt_next  = 3'h0;
          tx_two_next  = 1'b0;
          tx_line_next = 1'b0;
          tx_st_next   = TX_START;
        end
        TX_START: if (tx_tick) begin
          tx_line_next = tx_sh_reg[0];
          tx_st_next   = TX_DATA;
        end
        TX_DATA: if (tx_tick) begin
          tx_sh_next  = tx_sh_reg >> 1;
          tx_cnt_next = tx_cnt_reg + 3'h1;
          if (tx_cnt_reg == 3'h7) begin
            tx_line_next = cfg_reg.par_en ? tx_par_reg : 1'b1;
            tx_st_next   = cfg_reg.par_en ? TX_PAR : TX_STOP;
          end else begin
            tx_line_next = tx_sh_reg[1];
          end
        end
        TX_PAR: if (tx_tick) begin
          tx_line_next = 1'b1;
          tx_st_next   = TX_STOP;
        end
        TX_STOP: if (tx_tick) begin
          if (cfg_reg.two_stop && !tx_two_reg) begin
            tx_two_next = 1'b1;
          end else begin
            tx_done_evt = 1'b1;
            tx_st_next  = TX_IDLE;
          end
        end
      endcase
    end
  end

  // receiver
  always_comb begin
    rx_st_next   = rx_st_reg;
    rx_sh_next   = rx_sh_reg;
    rx_cnt_next  = rx_cnt_reg;
    rx_two_next  = rx_two_reg;
    rx_perr_next = rx_perr_reg;
    rx_fe_next   = rx_fe_reg;
    rx_deliver   = 1'b0;
    rx_fe_now    = rx_fe_reg || !rx_sync_reg;
    if (!port_on) begin
      rx_st_next = RX_IDLE;
    end else begin
      unique case (rx_st_reg)
        RX_IDLE: if (!rx_sync_reg) begin
          rx_st_next = RX_START;
        end
        RX_START: if (rx_tick) begin
          rx_st_next   = rx_sync_reg ? RX_IDLE : RX_DATA;  // glitch rejected
          rx_cnt_next  = 3'h0;
          rx_two_next  = 1'b0;
          rx_perr_next = 1'b0;
          rx_fe_next   = 1'b0;
        end
        RX_DATA: if (rx_tick) begin
          rx_sh_next  = {rx_sync_reg, rx_sh_reg[DW-1:1]};
          rx_cnt_next = rx_cnt_reg + 3'h1;
          if (rx_cnt_reg == 3'h7) begin
            rx_st_next = cfg_reg.par_en ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (rx_tick) begin
          rx_perr_next = rx_sync_reg != (cfg_reg.even ? ^rx_sh_reg : ~^rx_sh_reg);
          rx_st_next   = RX_STOP;
        end
        RX_STOP: if (rx_tick) begin
          if (cfg_reg.two_stop && !rx_two_reg) begin
            rx_two_next = 1'b1;
            rx_fe_next  = rx_fe_now;
          end else begin
            rx_deliver = 1'b1;
            rx_st_next = RX_IDLE;
          end
        end
      endcase
    end
  end

  // registers and flags; a hardware set always wins over a clear
  always_comb begin
    cfg_next                 = cfg_reg;
    en_next                  = en_reg;
    div_lo_next              = div_lo_reg;
    div_hi_next              = div_hi_reg;
    ls_next                  = ls_reg;
    rx_pending_irq_flag_next = rx_pending_irq_flag_reg;
    tx_done_irq_flag_next    = tx_done_irq_flag_reg;
    rxbuf_next               = rxbuf_reg;
    rxbuf_seen_next          = rxbuf_seen_reg;
    rdata_next               = rdata_reg;
    if (bus_wr) begin
      if (hit(bus_addr, `UAP_ADDR_CFG)) cfg_next = uap_cfg_t'({5'h00, bus_wdata[2:0]});
      if (hit(bus_addr, `UAP_ADDR_EN)) en_next = {7'h00, bus_wdata[0]};
      if (hit(bus_addr, `UAP_ADDR_DIV_LO)) div_lo_next = bus_wdata;
      if (hit(bus_addr, `UAP_ADDR_DIV_HI)) div_hi_next = bus_wdata;
      if (hit(bus_addr, `UAP_ADDR_IRQ)) begin
        rx_pending_irq_flag_next = rx_pending_irq_flag_reg && !bus_wdata[`UAP_IRQ_RX_BIT];
        tx_done_irq_flag_next    = tx_done_irq_flag_reg && !bus_wdata[`UAP_IRQ_TX_BIT];
      end
    end
    if (tx_push) ls_next.tx_done = 1'b0;
    if (rxbuf_rd) begin
      ls_next.rx_ready = 1'b0;
      rxbuf_seen_next  = 1'b1;
    end
    if (ls_rd && rxbuf_seen_reg) begin
      ls_next.oe      = 1'b0;
      ls_next.pe      = 1'b0;
      ls_next.fe      = 1'b0;
      rxbuf_seen_next = 1'b0;
    end
    if (rx_deliver) begin
      rxbuf_next               = rx_sh_reg;
      ls_next.oe               = ls_next.oe || (ls_reg.rx_ready && !rxbuf_rd);
      ls_next.pe               = ls_next.pe || rx_perr_reg;
      ls_next.fe               = ls_next.fe || rx_fe_now;
      ls_next.rx_ready         = 1'b1;
      rx_pending_irq_flag_next = 1'b1;
    end
    if (tx_done_evt && !fifo_vld) begin
      ls_next.tx_done       = 1'b1;
      tx_done_irq_flag_next = 1'b1;
    end
    if (bus_rd) begin
      rdata_next = `UAP_BYTE_ZERO;
      if (hit(bus_addr, `UAP_ADDR_CFG)) rdata_next = cfg_reg;
      if (hit(bus_addr, `UAP_ADDR_EN)) rdata_next = en_reg;
      if (hit(bus_addr, `UAP_ADDR_DIV_LO)) rdata_next = div_lo_reg;
      if (hit(bus_addr, `UAP_ADDR_DIV_HI)) rdata_next = div_hi_reg;
      if (hit(bus_addr, `UAP_ADDR_LINE)) rdata_next = ls_reg;
      if (hit(bus_addr, `UAP_ADDR_IRQ)) rdata_next = {6'h00, tx_done_irq_flag_reg, rx_pending_irq_flag_reg};
      if (hit(bus_addr, `UAP_ADDR_RXBUF)) rdata_next = rxbuf_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_reg                 <= uap_cfg_t'(`UAP_CFG_RST);
      en_reg                  <= `UAP_EN_RST;
      div_lo_reg              <= `UAP_DIV_RST;
      div_hi_reg              <= `UAP_DIV_RST;
      ls_reg                  <= uap_line_t'(`UAP_LINE_RST);
      rx_pending_irq_flag_reg <= 1'b0;
      tx_done_irq_flag_reg    <= 1'b0;
      rxbuf_reg               <= `UAP_BYTE_ZERO;
      rxbuf_seen_reg          <= 1'b0;
      rdata_reg               <= `UAP_BYTE_ZERO;
      space_reg               <= 1'b0;
      rx_meta_reg             <= 1'b1;
      rx_sync_reg             <= 1'b1;
      tx_st_reg               <= TX_IDLE;
      tx_sh_reg               <= `UAP_BYTE_ZERO;
      tx_cnt_reg              <= 3'h0;
      tx_par_reg              <= 1'b0;
      tx_two_reg              <= 1'b0;
      tx_line_reg             <= 1'b1;
      rx_st_reg               <= RX_IDLE;
      rx_sh_reg               <= `UAP_BYTE_ZERO;
      rx_cnt_reg              <= 3'h0;
      rx_two_reg              <= 1'b0;
      rx_perr_reg             <= 1'b0;
      rx_fe_reg               <= 1'b0;
    end else begin
      cfg_reg                 <= cfg_next;
      en_reg                  <= en_next;
      div_lo_reg              <= div_lo_next;
      div_hi_reg              <= div_hi_next;
      ls_reg                  <= ls_next;
      rx_pending_irq_flag_reg <= rx_pending_irq_flag_next;
      tx_done_irq_flag_reg    <= tx_done_irq_flag_next;
      rxbuf_reg               <= rxbuf_next;
      rxbuf_seen_reg          <= rxbuf_seen_next;
      rdata_reg               <= rdata_next;
      space_reg               <= fifo_in_rdy;
      rx_meta_reg             <= rx_line_in;
      rx_sync_reg             <= rx_meta_reg;
      tx_st_reg               <= tx_st_next;
      tx_sh_reg               <= tx_sh_next;
      tx_cnt_reg              <= tx_cnt_next;
      tx_par_reg              <= tx_par_next;
      tx_two_reg              <= tx_two_next;
      tx_line_reg             <= tx_line_next;
      rx_st_reg               <= rx_st_next;
      rx_sh_reg               <= rx_sh_next;
      rx_cnt_reg              <= rx_cnt_next;
      rx_two_reg              <= rx_two_next;
      rx_perr_reg             <= rx_perr_next;
      rx_fe_reg               <= rx_fe_next;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_launch;
    port_on && tx_pop;
  endsequence
  sequence s_start_bit;
    !tx_line_reg && (tx_st_reg == TX_START);
  endsequence

  a_parity_bit_value: assert property ((tx_st_reg == TX_PAR) |-> tx_line_reg == tx_par_reg)
    else $error("parity bit on line differs from computed parity");
  a_stop_bits_high: assert property ((tx_st_reg == TX_STOP) |-> tx_line_reg)
    else $error("stop bit not high");
  a_disabled_idle: assert property (!port_on |=> tx_line_reg && rx_st_reg == RX_IDLE)
    else $error("port disabled but still active");
  a_overrun_set: assert property (rx_deliver && ls_reg.rx_ready && !rxbuf_rd |=> ls_reg.oe)
    else $error("overrun not flagged");
  a_errors_clear: assert property (ls_rd && rxbuf_seen_reg && !rx_deliver |=> !ls_reg.oe && !ls_reg.pe && !ls_reg.fe)
    else $error("error flags not cleared by status read");
  a_errors_hold: assert property (ls_rd && !rxbuf_seen_reg && !rx_deliver |=> ls_reg.pe == $past(ls_reg.pe))
    else $error("parity error cleared without buffer read");
  a_parity_flag: assert property (rx_deliver && rx_perr_reg |=> ls_reg.pe)
    else $error("parity error not flagged");
  a_framing_flag: assert property (rx_deliver && rx_fe_now |=> ls_reg.fe)
    else $error("framing error not flagged");
  a_ready_cycle: assert property (rx_deliver |=> ls_reg.rx_ready ##0 (rxbuf_reg == $past(rx_sh_reg)))
    else $error("received character not presented");
  a_ready_clear: assert property (rxbuf_rd && !rx_deliver |=> !ls_reg.rx_ready && rxbuf_seen_reg)
    else $error("ready flag not cleared by buffer read");
  a_tx_complete: assert property (tx_done_evt && !fifo_vld |=> ls_reg.tx_done && tx_done_irq_flag_reg)
    else $error("transmit complete not flagged");
  a_tx_clear: assert property (tx_push && !tx_done_evt |=> !ls_reg.tx_done)
    else $error("transmit complete not cleared by write");
  a_tx_launch: assert property (s_launch |=> s_start_bit)
    else $error("start bit not driven after load");
  a_irq_w1c: assert property (bus_wr && hit(bus_addr, `UAP_ADDR_IRQ) && bus_wdata[0] && !rx_deliver
                              |=> !rx_pending_irq_flag_reg)
    else $error("receive interrupt flag not cleared");
endmodule

// File: sim/uap_remote_model.sv
// remote serial station: drives the receive pin and decodes the transmit pin
`timescale 1ns/1ps
module uap_remote_model #(
  parameter int P = 4
) (
  input  wire logic sys_clk,  // system clock
  input  wire logic tx_line,  // design transmit pin
  output logic      rx_line   // design receive pin, idle high
);
  initial rx_line = 1'b1;

  task automatic bit_out(input logic b);
    rx_line = b;
    repeat (P) @(negedge sys_clk);
  endtask

  // c: {two_stop, even, par_en}; bad_par and bad_stop break the frame on purpose
  task automatic send(input logic [7:0] d, input logic [2:0] c, input logic bad_par, input logic bad_stop);
    @(negedge sys_clk);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (c[0]) bit_out((c[1] ? ^d : ~^d) ^ bad_par);
    bit_out(~bad_stop);
    if (c[2]) bit_out(1'b1);
    rx_line = 1'b1;
  endtask

  // waits for a start bit, then samples n bits at mid-bit
  task automatic recv(input int n, output logic [10:0] b, output logic ok);
    int t;
    b = '0;
    t = 0;
    while (tx_line === 1'b1 && t < 5000) begin
      @(posedge sys_clk);
      t++;
    end
    ok = (t < 5000);
    repeat (P / 2) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      repeat (P) @(posedge sys_clk);
      b[i] = tx_line;
    end
  endtask
endmodule

// File: sim/tb_top.sv
// self-checking bench of the serial port
`timescale 1ns/1ps
`include "uap_params.svh"
module tb_top;
  import uap_pkg::*;
  localparam int P = 4;
  logic        sys_clk, rst, bus_wr, bus_rd, rx_line_in, tx_line_out, tx_space_ok, ok;
  logic [31:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, v, d;
  logic [10:0] bits;
  logic [7:0]  q[$];
  int          failures, check_count;

  uap_serial_port #(.FIFO_DEPTH(16)) uut (.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .rx_line_in(rx_line_in), .tx_line_out(tx_line_out), .tx_space_ok(tx_space_ok));
  uap_remote_model #(.P(P)) m (.sys_clk(sys_clk), .tx_line(tx_line_out), .rx_line(rx_line_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] dat);
    @(negedge sys_clk);
    bus_addr = a;
    bus_wdata = dat;
    bus_wr = 1'b1;
    @(negedge sys_clk);
    bus_wr = 1'b0;
  endtask

  task automatic rchk(input string what, input logic [31:0] a, input logic [7:0] mk, input logic [7:0] e);
    @(negedge sys_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge sys_clk);
    bus_rd = 1'b0;
    @(negedge sys_clk);
    check(what, {3'b000, e & mk}, {3'b000, bus_rdata & mk});
  endtask

  function automatic int nb(input logic [2:0] c);
    return 9 + c[0] + c[2];
  endfunction

  // expected samples after the start bit: data lsb first, parity, stop bits high
  function automatic logic [10:0] frame(input logic [7:0] dat, input logic [2:0] c);
    frame = {3'b111, dat};
    if (c[0]) frame[8] = c[1] ? ^dat : ~^dat;
    frame = frame & ((11'h001 << nb(c)) - 11'h001);
  endfunction

  task automatic rx_frame(input logic [2:0] c, input logic [7:0] dat);
    m.recv(nb(c), bits, ok);
    if (!ok) begin
      failures++;
      $display("ERROR tx start expected 0 seen 1");
      stop_test();
    end
    check("tx frame", frame(dat, c), bits);
  endtask

  initial begin
    rst = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 32'h00000000;
    bus_wdata = 8'h00;
    v = 8'($urandom(60868));
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) rchk("reset value", 32'h40000200 + i, 8'hFF, 8'h00);
    wr(`UAP_ADDR_CFG, 8'hFF);
    rchk("cfg", `UAP_ADDR_CFG, 8'hFF, 8'h07);
    wr(`UAP_ADDR_LINE, 8'hFF);
    rchk("line status", `UAP_ADDR_LINE, 8'hFF, 8'h00);
    wr(`UAP_ADDR_RXBUF, 8'h5A);
    rchk("rx buffer", `UAP_ADDR_RXBUF, 8'hFF, 8'h00);
    wr(`UAP_ADDR_DIV_LO, 8'h03);
    wr(`UAP_ADDR_DIV_HI, 8'h00);
    rchk("divisor", `UAP_ADDR_DIV_LO, 8'hFF, 8'h03);
    wr(`UAP_ADDR_EN, 8'h01);
    rchk("enable", `UAP_ADDR_EN, 8'hFF, 8'h01);
    $display("registers test done");
    for (int c = 0; c < 8; c++) begin
      wr(`UAP_ADDR_CFG, 8'(c));
      d = (c == 0) ? 8'h00 : (c == 7) ? 8'hFF : 8'($urandom);
      wr(`UAP_ADDR_TXBUF, d);
      rx_frame(c[2:0], d);
      rchk("tx busy", `UAP_ADDR_LINE, 8'h10, 8'h00);
      repeat (2 * P) @(negedge sys_clk);
      rchk("tx done", `UAP_ADDR_LINE, 8'h10, 8'h10);
      d = 8'($urandom);
      m.send(d, c[2:0], 1'b0, 1'b0);
      repeat (4) @(negedge sys_clk);
      rchk("rx ready", `UAP_ADDR_LINE, 8'h0F, 8'h08);
      rchk("irq rx", `UAP_ADDR_IRQ, 8'h03, 8'h03);
      wr(`UAP_ADDR_IRQ, 8'h03);
      rchk("irq cleared", `UAP_ADDR_IRQ, 8'h03, 8'h00);
      rchk("rx data", `UAP_ADDR_RXBUF, 8'hFF, d);
      rchk("rx empty", `UAP_ADDR_LINE, 8'h08, 8'h00);
    end
    $display("modes test done");
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'h0A : (k == 1) ? 8'h0C : 8'h09;
      d = 8'($urandom);
      if (k == 2) m.send(~d, 3'b111, 1'b0, 1'b0);
      if (k == 2) repeat (4) @(negedge sys_clk);
      m.send(d, 3'b111, k == 0, k == 1);
      repeat (4) @(negedge sys_clk);
      rchk("error flag", `UAP_ADDR_LINE, 8'h0F, v);
      rchk("flag held", `UAP_ADDR_LINE, 8'h0F, v);
      rchk("rx latest", `UAP_ADDR_RXBUF, 8'hFF, d);
      rchk("ready after read", `UAP_ADDR_LINE, 8'h08, 8'h00);
      rchk("flag cleared", `UAP_ADDR_LINE, 8'h0F, 8'h00);
    end
    $display("errors test done");
    wr(`UAP_ADDR_CFG, 8'h00);
    wr(`UAP_ADDR_EN, 8'h00);
    q = {};
    for (int i = 0; i < 17; i++) begin
      q.push_back(8'($urandom));
      wr(`UAP_ADDR_TXBUF, q[i]);
    end
    check("fifo room", 1'b0, tx_space_ok);
    m.send(8'h3C, 3'b000, 1'b0, 1'b0);
    check("idle line", 1'b1, tx_line_out);
    repeat (4) @(negedge sys_clk);
    rchk("rx while off", `UAP_ADDR_LINE, 8'h08, 8'h00);
    wr(`UAP_ADDR_EN, 8'h01);
    for (int i = 0; i < 16; i++) rx_frame(3'b000, q[i]);
    repeat (2 * P) @(negedge sys_clk);
    rchk("drained", `UAP_ADDR_LINE, 8'h10, 8'h10);
    check("fifo room back", 1'b1, tx_space_ok);
    $display("fifo test done");
    stop_test();
  end
endmodule
